// *** rtl/pct_map.svh ***
`ifndef PCT_MAP_SVH
`define PCT_MAP_SVH

// register offsets
`define PCT_OFF_REV 8'h01
`define PCT_OFF_SUBREV 8'h02
`define PCT_OFF_SUPPLY_CTRL 8'h10
`define PCT_OFF_SUPPLY_GOOD 8'h11
`define PCT_OFF_TICK_UNIT 8'h20
`define PCT_OFF_OFF_COUNT 8'h21
`define PCT_OFF_RUN_COUNT 8'h22
`define PCT_OFF_CYCLE_CTRL 8'h23

// field positions
`define PCT_BIT_RELEASE 6
`define PCT_BIT_SUPPLY_TWO 1
`define PCT_BIT_SUPPLY_ONE 0
`define PCT_BIT_GOOD_TWO 3
`define PCT_BIT_GOOD_ONE 2
`define PCT_BIT_TEN_S 3
`define PCT_BIT_ONE_S 2
`define PCT_BIT_HUNDRED_MS 1
`define PCT_BIT_TEN_MS 0
`define PCT_BIT_UPDATE 1
`define PCT_BIT_START 0

// fixed read fields and reset values
`define PCT_GOOD_LOW_FILL 2'h3
`define PCT_RST_SUPPLY_CTRL 2'h3
`define PCT_RST_TICK_UNIT 4'h2
`define PCT_RST_OFF_COUNT 8'h00

// ten-millisecond tick multiples per unit
`define PCT_MULT_TEN_S 10'h3E8
`define PCT_MULT_ONE_S 10'h064
`define PCT_MULT_HUNDRED_MS 10'h00A
`define PCT_MULT_TEN_MS 10'h001

// timing
`define PCT_TEN_MS_NS 10000000
`define PCT_CLK_PERIOD_NS 10

// serial slave address
`define PCT_I2C_ADDR 7'h3E

`endif

// *** rtl/pct_pkg.sv ***
`default_nettype none
package pct_pkg;
   typedef enum logic [2:0] {
      pct_i2c_idle,
      pct_i2c_addr,
      pct_i2c_ptr,
      pct_i2c_wr,
      pct_i2c_rd,
      pct_i2c_ign
   } pct_i2c_state_e;
   typedef logic [7:0] pct_byte_t;
endpackage
`default_nettype wire

// *** rtl/pct_regbus_if.sv ***
`default_nettype none
interface pct_regbus_if;
   import pct_pkg::*;
   pct_byte_t addr;
   pct_byte_t wdata;
   pct_byte_t rdata;
   logic wr;
   modport dev (input addr, input wdata, input wr, output rdata);
   modport ctl (output addr, output wdata, output wr, input rdata);
endinterface
`default_nettype wire

// *** rtl/pct_i2c_slave.sv ***
`include "pct_map.svh"
`default_nettype none
module pct_i2c_slave import pct_pkg::*; #(
   parameter logic [6:0] DEV_ADDR = `PCT_I2C_ADDR
) (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // serial pins
   input wire logic i_scl,
   input wire logic i_sda_in,
   output logic o_sda_oe_n,
   // register side
   pct_regbus_if.ctl rb
);
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   pct_i2c_state_e st, next_st;
   logic [3:0] bitcnt, next_bitcnt;
   logic in_ack, next_in_ack;
   pct_byte_t rx, next_rx, tx, next_tx, ptr, next_ptr, wdata, next_wdata;
   logic wr, next_wr, sda_oe_n, next_sda_oe_n;
   logic scl_rise, scl_fall, start_seen, stop_seen;

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
   assign rb.addr = ptr;
   assign rb.wdata = wdata;
   assign rb.wr = wr;
   assign o_sda_oe_n = sda_oe_n;

   // byte protocol
   always_comb begin
      next_st = st;
      next_bitcnt = bitcnt;
      next_in_ack = in_ack;
      next_rx = rx;
      next_tx = tx;
      next_ptr = ptr;
      next_wdata = wdata;
      next_wr = 1'b0;
      next_sda_oe_n = sda_oe_n;
      if (wr) begin
         next_ptr = ptr + 8'h01;
      end
      if (start_seen) begin
         next_st = pct_i2c_addr;
         next_bitcnt = 4'h0;
         next_in_ack = 1'b0;
         next_sda_oe_n = 1'b1;
      end else if (stop_seen) begin
         next_st = pct_i2c_idle;
         next_in_ack = 1'b0;
         next_sda_oe_n = 1'b1;
      end else if (st != pct_i2c_idle) begin
         if (scl_rise) begin
            if (bitcnt < 4'h8) begin
               next_rx = {rx[6:0], sda_s};
               next_bitcnt = bitcnt + 4'h1;
            end else if (st == pct_i2c_rd && sda_s) begin
               next_st = pct_i2c_ign;
            end
         end else if (scl_fall) begin
            if (!in_ack && bitcnt == 4'h8) begin
               next_in_ack = 1'b1;
               next_sda_oe_n = 1'b1;
               case (st)
                  pct_i2c_addr: begin
                     if (rx[7:1] == DEV_ADDR) begin
                        next_sda_oe_n = 1'b0;
                        next_st = rx[0] ? pct_i2c_rd : pct_i2c_ptr;
                        if (rx[0]) begin
                           next_tx = rb.rdata;
                           next_ptr = ptr + 8'h01;
                        end
                     end else begin
                        next_st = pct_i2c_ign;
                     end
                  end
                  pct_i2c_ptr: begin
                     next_ptr = rx;
                     next_st = pct_i2c_wr;
                     next_sda_oe_n = 1'b0;
                  end
                  pct_i2c_wr: begin
                     next_wr = 1'b1;
                     next_wdata = rx;
                     next_sda_oe_n = 1'b0;
                  end
                  pct_i2c_rd: begin
                     next_tx = rb.rdata;
                     next_ptr = ptr + 8'h01;
                  end
                  default: begin
                  end
               endcase
            end else if (in_ack) begin
               next_in_ack = 1'b0;
               next_bitcnt = 4'h0;
               next_sda_oe_n = (st == pct_i2c_rd) ? tx[7] : 1'b1;
            end else if (st == pct_i2c_rd && bitcnt != 4'h0) begin
               next_tx = {tx[6:0], 1'b0};
               next_sda_oe_n = tx[6];
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
         st <= pct_i2c_idle;
         bitcnt <= 4'h0;
         in_ack <= 1'b0;
         rx <= 8'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         wdata <= 8'h00;
         wr <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (i_ce) begin
         scl_m <= i_scl;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= i_sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
         st <= next_st;
         bitcnt <= next_bitcnt;
         in_ack <= next_in_ack;
         rx <= next_rx;
         tx <= next_tx;
         ptr <= next_ptr;
         wdata <= next_wdata;
         wr <= next_wr;
         sda_oe_n <= next_sda_oe_n;
      end
   end
endmodule
`default_nettype wire

// *** rtl/pct_power_cycle_timer.sv ***
// How it works
// - software programs the registers; supplies drop, wait, then return unaided.
// - revision register reads release flag in bit 6, revision in bits 5..0.
// - sub-revision register reads a fixed eight-bit debug number.
// - supply control bit 1 enables supply two, resets to one.
// - supply control bit 0 enables supply one, resets to one.
// - status reads supply two good bit 3, supply one bit 2, low bits 0x3.
// - one-hot tick unit: 10 s, 1 s, 100 ms, 10 ms; 100 ms after reset.
// - eight-bit off count setting; power returns when running count hits zero.
// - unit and count settings apply only when update bit is written one.
// - running counter value is readable in its own register.
// - writing one to start bit begins a power cycle.
`include "pct_map.svh"
`default_nettype none
module pct_power_cycle_timer import pct_pkg::*; #(
   parameter logic RELEASE_FLAG = 1'b0,
   parameter logic [5:0] LOGIC_REV = 6'h01,
   parameter pct_byte_t DEBUG_SUBREV = 8'h00,
   parameter logic [6:0] I2C_ADDR = `PCT_I2C_ADDR,
   parameter int TEN_MS_CYCLES = `PCT_TEN_MS_NS / `PCT_CLK_PERIOD_NS
) (
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // serial register port
   input wire logic i_scl,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   // supplies
   input wire logic i_supply_one_good,
   input wire logic i_supply_two_good,
   output logic o_supply_one_enable,
   output logic o_supply_two_enable,
   output logic o_cycle_busy
);
   localparam int PW = $clog2(TEN_MS_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TEN_MS_CYCLES - 1);

   pct_regbus_if rb ();

   pct_i2c_slave #(.DEV_ADDR(I2C_ADDR)) u_i2c (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_scl(i_scl),
      .i_sda_in(i_sda_in),
      .o_sda_oe_n(o_sda_oe_n),
      .rb(rb)
   );

   function automatic logic wr_hit(input logic wr, input pct_byte_t addr, input pct_byte_t off);
      wr_hit = wr && (addr == off);
   endfunction

   function automatic logic [9:0] unit_mult(input logic [3:0] base);
      if (base[`PCT_BIT_TEN_S]) begin
         unit_mult = `PCT_MULT_TEN_S;
      end else if (base[`PCT_BIT_ONE_S]) begin
         unit_mult = `PCT_MULT_ONE_S;
      end else if (base[`PCT_BIT_HUNDRED_MS]) begin
         unit_mult = `PCT_MULT_HUNDRED_MS;
      end else if (base[`PCT_BIT_TEN_MS]) begin
         unit_mult = `PCT_MULT_TEN_MS;
      end else begin
         unit_mult = `PCT_MULT_HUNDRED_MS;
      end
   endfunction

   logic [1:0] good_m, good_s;
   logic [1:0] supply_ctrl, next_supply_ctrl;
   logic [3:0] base_shadow, next_base_shadow, base_act, next_base_act;
   pct_byte_t cnt_shadow, next_cnt_shadow, cnt_act, next_cnt_act, run_cnt, next_run_cnt;
   logic busy, next_busy;
   logic [PW-1:0] pre_cnt, next_pre_cnt;
   logic [9:0] unit_cnt, next_unit_cnt;
   logic tick_ten_ms, unit_tick;
   logic en_one, en_two, sda_out;

   assign tick_ten_ms = busy && (pre_cnt == PRE_LAST);
   // unit change mid-cycle cannot skip the match
   assign unit_tick = tick_ten_ms && (unit_cnt >= unit_mult(base_act) - 10'h001);

   // register reads
   always_comb begin
      rb.rdata = 8'h00;
      case (rb.addr)
         `PCT_OFF_REV: rb.rdata = {1'b0, RELEASE_FLAG, LOGIC_REV};
         `PCT_OFF_SUBREV: rb.rdata = DEBUG_SUBREV;
         `PCT_OFF_SUPPLY_CTRL: rb.rdata = {6'h00, supply_ctrl};
         `PCT_OFF_SUPPLY_GOOD: rb.rdata = {4'h0, good_s[1], good_s[0], `PCT_GOOD_LOW_FILL};
         `PCT_OFF_TICK_UNIT: rb.rdata = {4'h0, base_shadow};
         `PCT_OFF_OFF_COUNT: rb.rdata = cnt_shadow;
         `PCT_OFF_RUN_COUNT: rb.rdata = run_cnt;
         `PCT_OFF_CYCLE_CTRL: rb.rdata = 8'h00;
         default: rb.rdata = 8'h00;
      endcase
   end

   // register writes and cycle sequencing
   always_comb begin
      next_supply_ctrl = supply_ctrl;
      next_base_shadow = base_shadow;
      next_cnt_shadow = cnt_shadow;
      next_base_act = base_act;
      next_cnt_act = cnt_act;
      next_busy = busy;
      next_run_cnt = run_cnt;
      next_pre_cnt = pre_cnt;
      next_unit_cnt = unit_cnt;
      if (wr_hit(rb.wr, rb.addr, `PCT_OFF_SUPPLY_CTRL)) begin
         next_supply_ctrl = rb.wdata[1:0];
      end
      if (wr_hit(rb.wr, rb.addr, `PCT_OFF_TICK_UNIT)) begin
         next_base_shadow = rb.wdata[3:0];
      end
      if (wr_hit(rb.wr, rb.addr, `PCT_OFF_OFF_COUNT)) begin
         next_cnt_shadow = rb.wdata;
      end
      if (wr_hit(rb.wr, rb.addr, `PCT_OFF_CYCLE_CTRL) && rb.wdata[`PCT_BIT_UPDATE]) begin
         next_base_act = base_shadow;
         next_cnt_act = cnt_shadow;
      end
      if (busy) begin
         if (run_cnt == 8'h00) begin
            next_busy = 1'b0;
         end else if (unit_tick) begin
            next_run_cnt = run_cnt - 8'h01;
         end
         next_pre_cnt = tick_ten_ms ? '0 : pre_cnt + PW'(1);
         if (unit_tick) begin
            next_unit_cnt = 10'h000;
         end else if (tick_ten_ms) begin
            next_unit_cnt = unit_cnt + 10'h001;
         end
      end else if (wr_hit(rb.wr, rb.addr, `PCT_OFF_CYCLE_CTRL) && rb.wdata[`PCT_BIT_START]) begin
         next_busy = 1'b1;
         next_run_cnt = next_cnt_act;
         next_pre_cnt = '0;
         next_unit_cnt = 10'h000;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         good_m <= 2'h0;
         good_s <= 2'h0;
         supply_ctrl <= `PCT_RST_SUPPLY_CTRL;
         base_shadow <= `PCT_RST_TICK_UNIT;
         cnt_shadow <= `PCT_RST_OFF_COUNT;
         base_act <= `PCT_RST_TICK_UNIT;
         cnt_act <= `PCT_RST_OFF_COUNT;
         busy <= 1'b0;
         run_cnt <= 8'h00;
         pre_cnt <= '0;
         unit_cnt <= 10'h000;
         en_one <= 1'b1;
         en_two <= 1'b1;
         sda_out <= 1'b0;
      end else if (i_ce) begin
         good_m <= {i_supply_two_good, i_supply_one_good};
         good_s <= good_m;
         supply_ctrl <= next_supply_ctrl;
         base_shadow <= next_base_shadow;
         cnt_shadow <= next_cnt_shadow;
         base_act <= next_base_act;
         cnt_act <= next_cnt_act;
         busy <= next_busy;
         run_cnt <= next_run_cnt;
         pre_cnt <= next_pre_cnt;
         unit_cnt <= next_unit_cnt;
         en_one <= next_supply_ctrl[`PCT_BIT_SUPPLY_ONE] & ~next_busy;
         en_two <= next_supply_ctrl[`PCT_BIT_SUPPLY_TWO] & ~next_busy;
         sda_out <= 1'b0;
      end
   end

   assign o_supply_one_enable = en_one;
   assign o_supply_two_enable = en_two;
   assign o_cycle_busy = busy;
   assign o_sda_out = sda_out;

   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   AST_REV_READ: assert property (rb.addr == `PCT_OFF_REV |-> rb.rdata == {1'b0, RELEASE_FLAG, LOGIC_REV})
      else $error("revision read wrong");
   AST_SUBREV_READ: assert property (rb.addr == `PCT_OFF_SUBREV |-> rb.rdata == DEBUG_SUBREV)
      else $error("sub-revision read wrong");
   AST_SUPPLY_WRITE: assert property (i_ce && rb.wr && rb.addr == `PCT_OFF_SUPPLY_CTRL |=>
      supply_ctrl == $past(rb.wdata[1:0]))
      else $error("supply control write lost");
   AST_OFF_WHILE_BUSY: assert property (busy |-> !o_supply_one_enable && !o_supply_two_enable)
      else $error("supply on during cycle");
   AST_GOOD_READ: assert property (rb.addr == `PCT_OFF_SUPPLY_GOOD |->
      rb.rdata[1:0] == `PCT_GOOD_LOW_FILL && rb.rdata[7:4] == 4'h0 && rb.rdata[3:2] == good_s)
      else $error("power-good read wrong");
   AST_NO_EARLY_APPLY: assert property (i_ce && rb.wr && rb.addr == `PCT_OFF_TICK_UNIT |=> $stable(base_act))
      else $error("unit applied without update");
   AST_UPDATE_APPLY: assert property (i_ce && rb.wr && rb.addr == `PCT_OFF_CYCLE_CTRL &&
      rb.wdata[`PCT_BIT_UPDATE] |=> base_act == $past(base_shadow) && cnt_act == $past(cnt_shadow))
      else $error("update not applied");
   AST_START: assert property (i_ce && !busy && rb.wr && rb.addr == `PCT_OFF_CYCLE_CTRL &&
      rb.wdata[`PCT_BIT_START] |=> busy && run_cnt == cnt_act)
      else $error("cycle did not start");
   AST_DECREMENT: assert property (i_ce && busy && unit_tick && run_cnt != 8'h00 |=>
      run_cnt == $past(run_cnt) - 8'h01)
      else $error("count did not step");
   AST_RESTORE: assert property (i_ce && busy && run_cnt == 8'h00 |=> !busy ##0
      o_supply_one_enable == supply_ctrl[`PCT_BIT_SUPPLY_ONE] &&
      o_supply_two_enable == supply_ctrl[`PCT_BIT_SUPPLY_TWO])
      else $error("power not restored");
   AST_CTRL_READ_ZERO: assert property (rb.addr == `PCT_OFF_CYCLE_CTRL |-> rb.rdata == 8'h00)
      else $error("control bits did not clear");
   AST_COUNT_READ: assert property (rb.addr == `PCT_OFF_RUN_COUNT |-> rb.rdata == run_cnt)
      else $error("running count read wrong");
endmodule
`default_nettype wire

// *** verification/pct_mgmt_master.sv ***
`include "pct_map.svh"
`default_nettype none
module pct_mgmt_master #(
   parameter logic [6:0] DEV_ADDR = `PCT_I2C_ADDR
) (
   // clock
   input wire logic i_clk,
   // serial pins
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned quarter = 4;
   initial begin
      o_scl = 1'h1;
      o_sda_oe_n = 1'h1;
   end
   task automatic step(input int unsigned n);
      repeat (n) @(posedge i_clk);
   endtask
   // one bit, data set mid low phase
   task automatic bit_io(input logic b, output logic r);
      step(quarter);
      o_sda_oe_n <= b;
      step(quarter);
      o_scl <= 1'h1;
      step(quarter);
      r = i_sda;
      step(quarter);
      o_scl <= 1'h0;
   endtask
   // start or repeated start
   task automatic start_c();
      step(quarter);
      o_sda_oe_n <= 1'h1;
      step(quarter);
      o_scl <= 1'h1;
      step(quarter);
      o_sda_oe_n <= 1'h0;
      step(quarter);
      o_scl <= 1'h0;
   endtask
   task automatic stop_c();
      step(quarter);
      o_sda_oe_n <= 1'h0;
      step(quarter);
      o_scl <= 1'h1;
      step(quarter);
      o_sda_oe_n <= 1'h1;
      step(quarter);
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], b);
         rx[i] = b;
      end
      bit_io(ack_in, ack_out);
   endtask
   task automatic write_reg(input logic [7:0] off, input logic [7:0] data, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2;
      start_c();
      byte_io({DEV_ADDR, 1'h0}, 1'h1, rx, a0);
      byte_io(off, 1'h1, rx, a1);
      byte_io(data, 1'h1, rx, a2);
      stop_c();
      ok = !(a0 | a1 | a2);
   endtask
   task automatic read_reg(input logic [7:0] off, output logic [7:0] data, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, a3;
      start_c();
      byte_io({DEV_ADDR, 1'h0}, 1'h1, rx, a0);
      byte_io(off, 1'h1, rx, a1);
      start_c();
      byte_io({DEV_ADDR, 1'h1}, 1'h1, rx, a2);
      byte_io(8'hFF, 1'h1, data, a3);
      stop_c();
      ok = !(a0 | a1 | a2);
   endtask
endmodule
`default_nettype wire

// *** verification/test_pct_power_cycle_timer.sv ***
`include "pct_map.svh"
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module test_pct_power_cycle_timer import pct_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TEN_MS = 4;
   localparam pct_byte_t UNIT [4] = '{8'h01, 8'h02, 8'h04, 8'h08};
   localparam int CNT [4] = '{5, 3, 2, 1};
   localparam int MULT [4] = '{1, 10, 100, 1000};
   logic i_clk = 1'h0;
   logic i_rst = 1'h1;
   logic good1 = 1'h1;
   logic good2 = 1'h1;
   logic ce = 1'h1;
   logic scl, mst_oe_n, dut_oe_n, dut_sda_out, en1, en2, busy, ok;
   logic sda_line;
   logic [15:0] off_run = 16'h0000;
   logic [15:0] last_off = 16'h0000;
   pct_byte_t rd;
   int bad_count = 0;
   int compares = 0;
   // open-drain line with pull-up
   assign sda_line = mst_oe_n & (dut_oe_n | dut_sda_out);
   pct_power_cycle_timer #(.RELEASE_FLAG(1'h1), .LOGIC_REV(6'h2A), .DEBUG_SUBREV(8'h5C), .TEN_MS_CYCLES(TEN_MS)) i_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_scl(scl), .i_sda_in(sda_line), .o_sda_out(dut_sda_out),
      .o_sda_oe_n(dut_oe_n), .i_supply_one_good(good1), .i_supply_two_good(good2),
      .o_supply_one_enable(en1), .o_supply_two_enable(en2), .o_cycle_busy(busy));
   pct_mgmt_master i_mst (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_oe_n(mst_oe_n));
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   // length of supply-off windows
   always @(posedge i_clk) begin
      if (en1 === 1'h0) begin
         off_run <= off_run + 16'h0001;
      end else if (off_run != 16'h0000) begin
         last_off <= off_run;
         off_run <= 16'h0000;
      end
   end
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wr(input pct_byte_t a, input pct_byte_t d);
      i_mst.write_reg(a, d, ok);
      `CHK(ok, 1'h1)
   endtask
   task automatic rdchk(input pct_byte_t a, input pct_byte_t exp, input pct_byte_t mask);
      i_mst.read_reg(a, rd, ok);
      `CHK(ok, 1'h1)
      `CHK(rd & mask, exp)
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      #1;
      while (busy !== 1'h0 && n < 20000) begin
         @(posedge i_clk);
         n++;
      end
      if (n >= 20000) begin
         bad_count++;
         end_of_test();
      end
   endtask
   task automatic off_chk(input int exp);
      wait_idle();
      repeat (3) @(posedge i_clk);
      #1;
      `CHK(last_off, exp + 1)
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst <= 1'h0;
      repeat (4) @(posedge i_clk);
      rdchk(8'h01, 8'h6A, 8'h7F);
      rdchk(8'h02, 8'h5C, 8'hFF);
      rdchk(8'h10, 8'h03, 8'h03);
      rdchk(8'h20, 8'h02, 8'h0F);
      rdchk(8'h21, 8'h00, 8'hFF);
      rdchk(8'h22, 8'h00, 8'hFF);
      rdchk(8'h23, 8'h00, 8'h03);
      rdchk(8'h30, 8'h00, 8'hFF);
      for (int g = 0; g < 4; g++) begin
         @(posedge i_clk);
         good1 <= g[0];
         good2 <= g[1];
         repeat (4) @(posedge i_clk);
         rdchk(8'h11, {4'h0, g[1], g[0], 2'h3}, 8'h0F);
      end
      good1 <= 1'h1;
      good2 <= 1'h1;
      wr(8'h10, 8'h01);
      `CHK({en2, en1}, 2'h1)
      wr(8'h10, 8'h02);
      `CHK({en2, en1}, 2'h2)
      rdchk(8'h10, 8'h02, 8'h03);
      wr(8'h10, 8'h03);
      wr(8'h21, 8'h05);
      wr(8'h20, 8'h01);
      rdchk(8'h20, 8'h01, 8'h0F);
      wr(8'h23, 8'h01);
      off_chk(0);
      wr(8'h23, 8'h02);
      rdchk(8'h23, 8'h00, 8'h03);
      wr(8'h23, 8'h01);
      off_chk(5 * TEN_MS);
      for (int i = 0; i < 4; i++) begin
         i_mst.quarter = (i == 2) ? 7 : 4;
         wr(8'h20, UNIT[i]);
         wr(8'h21, CNT[i][7:0]);
         wr(8'h23, 8'h03);
         if (i > 0) begin
            `CHK({busy, en2, en1}, 3'h4)
         end
         if (i == 3) begin
            rdchk(8'h22, CNT[i][7:0], 8'hFF);
            wr(8'h23, 8'h01);
            // enable low freezes the count
            ce <= 1'h0;
            repeat (100) @(posedge i_clk);
            `CHK({busy, en2, en1}, 3'h4)
            ce <= 1'h1;
         end
         off_chk(CNT[i] * MULT[i] * TEN_MS + ((i == 3) ? 100 : 0));
         `CHK({en2, en1}, 2'h3)
         rdchk(8'h22, 8'h00, 8'hFF);
      end
      wr(8'h10, 8'h01);
      wr(8'h21, 8'h02);
      wr(8'h20, 8'h01);
      wr(8'h23, 8'h03);
      off_chk(2 * TEN_MS);
      `CHK({en2, en1}, 2'h1)
      // two unit bits set: larger unit counts
      wr(8'h20, 8'h03);
      wr(8'h21, 8'h01);
      wr(8'h23, 8'h03);
      off_chk(10 * TEN_MS);
      end_of_test();
   end
endmodule
`default_nettype wire
